// >>> design/sbio_bridge.sv
`timescale 1ns/1ps
`default_nettype none
`include "sbio_defines.svh"

module sbio_bridge #(
    parameter int NUM_PINS = `SBIO_NUM_PINS,
    parameter int BIT_CYCLES = `SBIO_BIT_CYCLES,
    parameter int SLOW_HALF_CYCLES = `SBIO_SLOW_HALF_CYCLES,
    parameter int FAST_HALF_CYCLES = `SBIO_FAST_HALF_CYCLES
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic rx_i,
    output logic tx_o,
    input wire logic [NUM_PINS-1:0] pin_in_i,
    output logic [NUM_PINS-1:0] pin_out_o,
    output logic [NUM_PINS-1:0] pin_oe_o,
    input wire logic [`SBIO_ADDR_W-1:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o
);
    import sbio_pkg::*;

    localparam logic [15:0] BIT_CNT = 16'(BIT_CYCLES - 1);
    localparam logic [15:0] HALF_CNT = 16'(BIT_CYCLES / 2 - 1);
    localparam logic [31:0] SLOW_CNT = 32'(SLOW_HALF_CYCLES - 1);
    localparam logic [31:0] FAST_CNT = 32'(FAST_HALF_CYCLES - 1);

    // ****************************************************************
    // serial receiver
    // ****************************************************************
    sbio_ser_state_t rx_state_reg, rx_state_next;
    logic [15:0] rx_cnt_reg, rx_cnt_next;
    logic [2:0] rx_bit_reg, rx_bit_next;
    logic [7:0] rx_shift_reg, rx_shift_next;
    logic rx_valid_reg, rx_valid_next;

    always_comb begin
        rx_state_next = rx_state_reg;
        rx_cnt_next = rx_cnt_reg;
        rx_bit_next = rx_bit_reg;
        rx_shift_next = rx_shift_reg;
        rx_valid_next = 1'b0;
        unique case (rx_state_reg)
            SER_IDLE: begin
                rx_cnt_next = 16'h0000;
                if (!rx_i) begin
                    rx_state_next = SER_START;
                end
            end
            SER_START: begin
                rx_cnt_next = rx_cnt_reg + 16'h0001;
                if (rx_cnt_reg == HALF_CNT) begin
                    rx_cnt_next = 16'h0000;
                    rx_bit_next = 3'h0;
                    rx_state_next = rx_i ? SER_IDLE : SER_DATA;
                end
            end
            SER_DATA: begin
                rx_cnt_next = rx_cnt_reg + 16'h0001;
                if (rx_cnt_reg == BIT_CNT) begin
                    rx_cnt_next = 16'h0000;
                    rx_shift_next = {rx_i, rx_shift_reg[7:1]};
                    rx_bit_next = rx_bit_reg + 3'h1;
                    if (rx_bit_reg == 3'h7) begin
                        rx_state_next = SER_STOP;
                    end
                end
            end
            SER_STOP: begin
                rx_cnt_next = rx_cnt_reg + 16'h0001;
                if (rx_cnt_reg == BIT_CNT) begin
                    rx_valid_next = rx_i;
                    rx_state_next = SER_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            rx_state_reg <= SER_IDLE;
            rx_cnt_reg <= 16'h0000;
            rx_bit_reg <= 3'h0;
            rx_shift_reg <= 8'h00;
            rx_valid_reg <= 1'b0;
        end else begin
            rx_state_reg <= rx_state_next;
            rx_cnt_reg <= rx_cnt_next;
            rx_bit_reg <= rx_bit_next;
            rx_shift_reg <= rx_shift_next;
            rx_valid_reg <= rx_valid_next;
        end
    end

    // ****************************************************************
    // serial transmitter
    // ****************************************************************
    sbio_ser_state_t tx_state_reg, tx_state_next;
    logic [15:0] tx_cnt_reg, tx_cnt_next;
    logic [2:0] tx_bit_reg, tx_bit_next;
    logic [7:0] tx_shift_reg, tx_shift_next;
    logic tx_next;
    logic tx_start;
    logic [7:0] tx_byte;

    always_comb begin
        tx_state_next = tx_state_reg;
        tx_cnt_next = tx_cnt_reg + 16'h0001;
        tx_bit_next = tx_bit_reg;
        tx_shift_next = tx_shift_reg;
        tx_next = tx_o;
        unique case (tx_state_reg)
            SER_IDLE: begin
                tx_cnt_next = 16'h0000;
                tx_next = 1'b1;
                if (tx_start) begin
                    tx_shift_next = tx_byte;
                    tx_next = 1'b0;
                    tx_state_next = SER_START;
                end
            end
            SER_START: begin
                if (tx_cnt_reg == BIT_CNT) begin
                    tx_cnt_next = 16'h0000;
                    tx_bit_next = 3'h0;
                    tx_next = tx_shift_reg[0];
                    tx_state_next = SER_DATA;
                end
            end
            SER_DATA: begin
                if (tx_cnt_reg == BIT_CNT) begin
                    tx_cnt_next = 16'h0000;
                    tx_bit_next = tx_bit_reg + 3'h1;
                    tx_shift_next = {1'b0, tx_shift_reg[7:1]};
                    tx_next = tx_shift_reg[1];
                    if (tx_bit_reg == 3'h7) begin
                        tx_next = 1'b1;
                        tx_state_next = SER_STOP;
                    end
                end
            end
            SER_STOP: begin
                if (tx_cnt_reg == BIT_CNT) begin
                    tx_state_next = SER_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            tx_state_reg <= SER_IDLE;
            tx_cnt_reg <= 16'h0000;
            tx_bit_reg <= 3'h0;
            tx_shift_reg <= 8'h00;
            tx_o <= 1'b1;
        end else begin
            tx_state_reg <= tx_state_next;
            tx_cnt_reg <= tx_cnt_next;
            tx_bit_reg <= tx_bit_next;
            tx_shift_reg <= tx_shift_next;
            tx_o <= tx_next;
        end
    end

    // ****************************************************************
    // banner memory
    // ****************************************************************
    logic [3:0] bnr_idx_reg, bnr_idx_next;
    logic [7:0] bnr_data;

    sbio_banner_rom u_rom (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .addr_i(bnr_idx_reg),
        .data_o(bnr_data)
    );

    // ****************************************************************
    // command engine, blink and pin state
    // ****************************************************************
    sbio_ctl_state_t ct_state_reg, ct_state_next;
    logic [7:0] first_reg, first_next;
    logic [7:0] reply_reg, reply_next;
    logic [2:0] ctrl_reg, ctrl_next;
    logic [NUM_PINS-1:0] val_reg, val_next;
    logic [NUM_PINS-1:0] drv_reg, drv_next;
    logic [31:0] blink_cnt_reg, blink_cnt_next;
    logic blink_ph_reg, blink_ph_next;
    logic [31:0] rdata_next;
    logic [3:0] pin_num;
    logic pin_ok;
    logic [3:0] pin_idx;

    assign pin_num = first_reg[3:0];
    assign pin_idx = pin_num - 4'h1;
    assign pin_ok = (pin_num >= `SBIO_PIN_MIN) && (pin_num <= `SBIO_PIN_MAX);

    always_comb begin
        ct_state_next = ct_state_reg;
        first_next = first_reg;
        reply_next = reply_reg;
        ctrl_next = ctrl_reg;
        val_next = val_reg;
        drv_next = drv_reg;
        bnr_idx_next = bnr_idx_reg;
        tx_start = 1'b0;
        tx_byte = reply_reg;
        rdata_next = 32'h0000_0000;
        unique case (ct_state_reg)
            CT_FETCH: begin
                ct_state_next = CT_BANNER;
            end
            CT_BANNER: begin
                if (tx_state_reg == SER_IDLE) begin
                    tx_start = 1'b1;
                    tx_byte = bnr_data;
                    bnr_idx_next = bnr_idx_reg + 4'h1;
                    ct_state_next = (bnr_idx_reg == `SBIO_BANNER_LEN - 4'h1)
                        ? CT_FIRST : CT_FETCH;
                end
            end
            CT_FIRST: begin
                if (rx_valid_reg) begin
                    first_next = rx_shift_reg;
                    ct_state_next = CT_SECOND;
                end
            end
            CT_SECOND: begin
                if (rx_valid_reg) begin
                    ct_state_next = CT_REPLY;
                    reply_next = `SBIO_ERR;
                    if (first_reg[7:4] == `SBIO_OP_READ && pin_ok) begin
                        reply_next = {7'h00, pin_in_i[pin_idx]};
                    end else if (first_reg[7:4] == `SBIO_OP_WRITE && pin_ok
                        && rx_shift_reg[7:1] == 7'h00) begin
                        val_next[pin_idx] = rx_shift_reg[0];
                        drv_next[pin_idx] = 1'b1;
                        reply_next = `SBIO_ACK_WRITE;
                    end else if (rx_shift_reg[7:1] == 7'h00) begin
                        if (first_reg == `SBIO_CMD_BLINK_EN) begin
                            ctrl_next[`SBIO_CTRL_BLINK_EN] = rx_shift_reg[0];
                            reply_next = `SBIO_ACK_BLINK_EN;
                        end else if (first_reg == `SBIO_CMD_BLINK_RATE) begin
                            ctrl_next[`SBIO_CTRL_BLINK_FAST] = rx_shift_reg[0];
                            reply_next = `SBIO_ACK_BLINK_RATE;
                        end
                    end
                end
            end
            CT_REPLY: begin
                if (tx_state_reg == SER_IDLE) begin
                    tx_start = 1'b1;
                    ct_state_next = CT_FIRST;
                end
            end
            default: begin
                ct_state_next = CT_FIRST;
            end
        endcase
        if (reg_wr_i && reg_addr_i == `SBIO_REG_CTRL) begin
            ctrl_next = reg_wdata_i[2:0];
        end
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                `SBIO_REG_CTRL: rdata_next = {29'h0, ctrl_reg};
                `SBIO_REG_PINS: rdata_next = 32'(pin_in_i);
                `SBIO_REG_DRIVE: rdata_next = 32'(pin_oe_o);
                default: rdata_next = 32'h0000_0000;
            endcase
        end
    end

    always_comb begin
        blink_cnt_next = blink_cnt_reg + 32'h0000_0001;
        blink_ph_next = blink_ph_reg;
        if (!ctrl_reg[`SBIO_CTRL_BLINK_EN]) begin
            blink_cnt_next = 32'h0000_0000;
            blink_ph_next = 1'b0;
        end else if (blink_cnt_reg >= (ctrl_reg[`SBIO_CTRL_BLINK_FAST]
            ? FAST_CNT : SLOW_CNT)) begin
            blink_cnt_next = 32'h0000_0000;
            blink_ph_next = !blink_ph_reg;
        end
    end

    // ****************************************************************
    // pin drivers
    // ****************************************************************
    logic [NUM_PINS-1:0] oe_next;
    logic [NUM_PINS-1:0] out_next;

    generate
        for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
            if (i == `SBIO_IND_BIT) begin : g_ind
                assign out_next[i] = 1'b0;
                assign oe_next[i] = ctrl_reg[`SBIO_CTRL_BLINK_EN]
                    ? blink_ph_reg : !val_reg[i];
            end else if (i == `SBIO_CLK_LINE_BIT
                || i == `SBIO_DATA_LINE_BIT) begin : g_tw
                assign out_next[i] = ctrl_reg[`SBIO_CTRL_TWO_WIRE]
                    ? 1'b0 : val_reg[i];
                assign oe_next[i] = ctrl_reg[`SBIO_CTRL_TWO_WIRE]
                    ? (drv_reg[i] && !val_reg[i]) : drv_reg[i];
            end else begin : g_gen
                assign out_next[i] = val_reg[i];
                assign oe_next[i] = drv_reg[i];
            end
        end
    endgenerate

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            ct_state_reg <= CT_FETCH;
            first_reg <= 8'h00;
            reply_reg <= 8'h00;
            ctrl_reg <= `SBIO_CTRL_RESET;
            val_reg <= '0;
            drv_reg <= '0;
            bnr_idx_reg <= 4'h0;
            blink_cnt_reg <= 32'h0000_0000;
            blink_ph_reg <= 1'b0;
            reg_rdata_o <= 32'h0000_0000;
            pin_out_o <= '0;
            pin_oe_o <= '0;
        end else begin
            ct_state_reg <= ct_state_next;
            first_reg <= first_next;
            reply_reg <= reply_next;
            ctrl_reg <= ctrl_next;
            val_reg <= val_next;
            drv_reg <= drv_next;
            bnr_idx_reg <= bnr_idx_next;
            blink_cnt_reg <= blink_cnt_next;
            blink_ph_reg <= blink_ph_next;
            reg_rdata_o <= rdata_next;
            pin_out_o <= out_next;
            pin_oe_o <= oe_next;
        end
    end

endmodule : sbio_bridge
`default_nettype wire

// >>> design/sbio_defines.svh
// Behaviour
// - general pins tristate, push-pull, always readable
// - indicator open-drain, one floats, zero pulls
// - clock line open-drain in two-wire mode
// - data line open-drain in two-wire mode
// - held in reset while DTR inactive
// - banner sent over serial at start-up
// - after reset all but indicator inputs
// - indicator blinks slowly after reset
// - blink switchable off, or to fast rate
// - indicator blinks until host disables it
// - pin written zero/one, read by command
// - success byte after command, else error byte
// - read 0xE#, write 0xF# with 0/1
// - 0xC0 blink on/off, 0xC1 rate
`ifndef SBIO_DEFINES_SVH
`define SBIO_DEFINES_SVH

// ****************************************************************
// clock and serial timing
// ****************************************************************
`define SBIO_CLK_HZ 100000000
`define SBIO_BAUD 57600
`define SBIO_BIT_CYCLES (`SBIO_CLK_HZ / `SBIO_BAUD)
`define SBIO_SLOW_HALF_MS 500
`define SBIO_FAST_HALF_MS 125
`define SBIO_SLOW_HALF_CYCLES (`SBIO_CLK_HZ / 1000 * `SBIO_SLOW_HALF_MS)
`define SBIO_FAST_HALF_CYCLES (`SBIO_CLK_HZ / 1000 * `SBIO_FAST_HALF_MS)

// ****************************************************************
// pins
// ****************************************************************
`define SBIO_NUM_PINS 11
`define SBIO_IND_BIT 2
`define SBIO_CLK_LINE_BIT 9
`define SBIO_DATA_LINE_BIT 10

// ****************************************************************
// command bytes
// ****************************************************************
`define SBIO_OP_READ 4'hE
`define SBIO_OP_WRITE 4'hF
`define SBIO_CMD_BLINK_EN 8'hC0
`define SBIO_CMD_BLINK_RATE 8'hC1
`define SBIO_ACK_WRITE 8'hF0
`define SBIO_ACK_BLINK_EN 8'hD0
`define SBIO_ACK_BLINK_RATE 8'hD1
`define SBIO_ERR 8'hFA
`define SBIO_ARG_ZERO 8'h00
`define SBIO_ARG_ONE 8'h01
`define SBIO_PIN_MIN 4'h1
`define SBIO_PIN_MAX 4'hB

// ****************************************************************
// banner
// ****************************************************************
`define SBIO_BANNER_LEN 4'h9

// ****************************************************************
// registers
// ****************************************************************
`define SBIO_ADDR_W 4
`define SBIO_REG_CTRL 4'h0
`define SBIO_REG_PINS 4'h4
`define SBIO_REG_DRIVE 4'h8
`define SBIO_CTRL_BLINK_EN 0
`define SBIO_CTRL_BLINK_FAST 1
`define SBIO_CTRL_TWO_WIRE 2
`define SBIO_CTRL_RESET 3'h1

`endif

// >>> design/sbio_pkg.sv
package sbio_pkg;

    typedef enum logic [1:0] {
        SER_IDLE,
        SER_START,
        SER_DATA,
        SER_STOP
    } sbio_ser_state_t;

    typedef enum logic [2:0] {
        CT_FETCH,
        CT_BANNER,
        CT_FIRST,
        CT_SECOND,
        CT_REPLY
    } sbio_ctl_state_t;

endpackage : sbio_pkg

// >>> design/sbio_banner_rom.sv
`timescale 1ns/1ps
`default_nettype none
`include "sbio_defines.svh"

module sbio_banner_rom (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [3:0] addr_i,
    output logic [7:0] data_o
);

    // ****************************************************************
    // banner text, arbitrary neutral value
    // ****************************************************************
    logic [7:0] data_next;

    always_comb begin
        unique case (addr_i)
            4'h0: data_next = 8'h53;
            4'h1: data_next = 8'h42;
            4'h2: data_next = 8'h49;
            4'h3: data_next = 8'h4F;
            4'h4: data_next = 8'h20;
            4'h5: data_next = 8'h72;
            4'h6: data_next = 8'h30;
            4'h7: data_next = 8'h2E;
            4'h8: data_next = 8'h31;
            default: data_next = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            data_o <= 8'h00;
        end else begin
            data_o <= data_next;
        end
    end

endmodule : sbio_banner_rom
`default_nettype wire

// >>> bench/sbio_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ********
// host serial port
// ********
module sbio_host_model #(
    parameter int BIT_CYCLES = 16
) (
    input wire logic clk_i,
    input wire logic line_i,
    output logic line_o
);
    logic [7:0] rx_q[$];
    initial line_o = 1'b1;
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            line_o <= f[i];
            repeat (BIT_CYCLES) @(posedge clk_i);
        end
    endtask : send
    initial begin
        logic [7:0] b;
        forever begin
            @(negedge line_i);
            repeat (BIT_CYCLES / 2) @(posedge clk_i);
            for (int i = 0; i < 8; i++) begin
                repeat (BIT_CYCLES) @(posedge clk_i);
                b[i] = line_i;
            end
            repeat (BIT_CYCLES) @(posedge clk_i);
            if (line_i) rx_q.push_back(b);
        end
    end
endmodule : sbio_host_model
`default_nettype wire

// >>> bench/sbio_bridge_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "sbio_defines.svh"
// ********
// port checks
// ********
module sbio_bridge_monitor #(
    parameter int NUM_PINS = 11,
    parameter int BIT_CYCLES = 16,
    parameter int SLOW_HALF_CYCLES = 40,
    parameter int FAST_HALF_CYCLES = 10
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic rx_i,
    input wire logic tx_o,
    input wire logic [NUM_PINS-1:0] pin_in_i,
    input wire logic [NUM_PINS-1:0] pin_out_o,
    input wire logic [NUM_PINS-1:0] pin_oe_o,
    input wire logic [`SBIO_ADDR_W-1:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [31:0] reg_rdata_o
);
    logic [31:0] since_reg, since_next;
    logic tw_reg, tw_next, tw_d_reg;
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    always_comb begin
        since_next = since_reg;
        if (since_reg != 32'hFFFFFFFF) since_next = since_reg + 32'h1;
        tw_next = tw_reg;
        if (reg_wr_i && reg_addr_i == 4'h0) tw_next = reg_wdata_i[2];
    end
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            since_reg <= 32'h0;
            tw_reg <= 1'b0;
            tw_d_reg <= 1'b0;
        end else begin
            since_reg <= since_next;
            tw_reg <= tw_next;
            tw_d_reg <= tw_reg;
        end
    end
    a_rel_quiet: assert property (
        $fell(reset_i) |-> tx_o && pin_oe_o == '0)
        else $error("outputs not quiet after release");
    a_banner_start: assert property (
        $fell(reset_i) |-> ##[1:4] !tx_o)
        else $error("banner start bit missing");
    a_ind_quiet: assert property (
        since_reg < SLOW_HALF_CYCLES - 2 |-> !pin_oe_o[`SBIO_IND_BIT])
        else $error("indicator pulled low too early");
    a_ind_blink: assert property (
        since_reg == SLOW_HALF_CYCLES + 2 |-> pin_oe_o[`SBIO_IND_BIT])
        else $error("indicator did not toggle");
    a_ind_drain: assert property (pin_out_o[`SBIO_IND_BIT] == 1'b0)
        else $error("indicator driven high");
    a_rd_pins: assert property (
        $past(reg_rd_i) && $past(reg_addr_i) == `SBIO_REG_PINS
        |-> reg_rdata_o == 32'($past(pin_in_i)))
        else $error("pin level read wrong");
    a_rd_drive: assert property (
        $past(reg_rd_i) && $past(reg_addr_i) == `SBIO_REG_DRIVE
        |-> reg_rdata_o == 32'($past(pin_oe_o)))
        else $error("drive read wrong");
    a_tw_clock: assert property (
        tw_reg && tw_d_reg |-> !pin_out_o[`SBIO_CLK_LINE_BIT])
        else $error("clock line driven high");
    a_tw_data: assert property (
        tw_reg && tw_d_reg |-> !pin_out_o[`SBIO_DATA_LINE_BIT])
        else $error("data line driven high");
    a_start_bit: assert property ($fell(tx_o) |-> !tx_o [*8])
        else $error("start bit too short");
    c_tx: cover property ($fell(tx_o));
    c_tw: cover property (tw_reg && pin_oe_o[`SBIO_CLK_LINE_BIT]);
    c_blink: cover property ($rose(pin_oe_o[`SBIO_IND_BIT]));
endmodule : sbio_bridge_monitor
bind sbio_bridge sbio_bridge_monitor #(
    .NUM_PINS(NUM_PINS), .BIT_CYCLES(BIT_CYCLES),
    .SLOW_HALF_CYCLES(SLOW_HALF_CYCLES), .FAST_HALF_CYCLES(FAST_HALF_CYCLES)
) i_mon (
    .clk_i(clk_i), .reset_i(reset_i), .rx_i(rx_i), .tx_o(tx_o),
    .pin_in_i(pin_in_i), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o)
);
`default_nettype wire

// >>> bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ********
// bridge bench
// ********
module tb_top;
    localparam int BITC = 16;
    localparam int SLOW = 40;
    localparam int FAST = 10;
    // arbitrary banner text
    localparam logic [71:0] BANNER = "SBIO r0.1";
    logic clk_i, reset_i, host_tx, dev_tx, reg_wr_i, reg_rd_i;
    logic [10:0] pin_in_i, pin_out_o, pin_oe_o, wr_m, val_m;
    logic [3:0] reg_addr_i;
    logic [31:0] reg_wdata_i, reg_rdata_o, d;
    logic [15:0] bad [6] = '{16'hF001, 16'hFC00, 16'hF102, 16'hC002,
        16'hA000, 16'hE000};
    int errors, checks, tw_m, n;
    sbio_bridge #(.BIT_CYCLES(BITC), .SLOW_HALF_CYCLES(SLOW),
        .FAST_HALF_CYCLES(FAST)) i_sbio_bridge (
        .clk_i(clk_i), .reset_i(reset_i), .rx_i(host_tx), .tx_o(dev_tx),
        .pin_in_i(pin_in_i), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o));
    sbio_host_model #(.BIT_CYCLES(BITC)) i_sbio_host_model (
        .clk_i(clk_i), .line_i(dev_tx), .line_o(host_tx));
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    task automatic results();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : results
    task automatic check(input string s, input logic [31:0] e, g);
        checks++;
        if (g !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", s, e, g);
        end
    endtask : check
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= v;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1 v = reg_rdata_o;
    endtask : rd
    task automatic get(output logic [7:0] b);
        int k;
        k = 0;
        while (i_sbio_host_model.rx_q.size() == 0) begin
            @(posedge clk_i);
            k++;
            if (k > 400 * BITC) begin
                errors++;
                $display("ERROR reply_wait expected %0d seen %0d", 400 * BITC, k);
                results();
            end
        end
        b = i_sbio_host_model.rx_q.pop_front();
    endtask : get
    task automatic banner();
        logic [7:0] b;
        for (int i = 0; i < 9; i++) begin
            get(b);
            check("banner", 32'(BANNER[71-8*i -: 8]), 32'(b));
        end
    endtask : banner
    task automatic model(input logic [7:0] b1, b2, output logic [7:0] r);
        int p;
        logic ok;
        p = int'(b1[3:0]);
        ok = p >= 1 && p <= 11;
        r = 8'hFA;
        if (b1[7:4] == 4'hE && ok) r = {7'h00, pin_in_i[p-1]};
        else if (b2 > 8'h01) return;
        else if (b1[7:4] == 4'hF && ok) begin
            wr_m[p-1] = 1'b1;
            val_m[p-1] = b2[0];
            r = 8'hF0;
        end else if (b1 == 8'hC0) r = 8'hD0;
        else if (b1 == 8'hC1) r = 8'hD1;
    endtask : model
    task automatic pins_chk();
        logic [10:0] eo, eu;
        eo = wr_m & 11'h7FB;
        eu = val_m & eo;
        if (tw_m != 0) begin
            eo[10:9] = wr_m[10:9] & ~val_m[10:9];
            eu[10:9] = 2'b00;
        end
        check("pin_oe", 32'(eo), 32'(pin_oe_o & 11'h7FB));
        check("pin_out", 32'(eu), 32'(pin_out_o & eo));
    endtask : pins_chk
    task automatic cmd(input logic [7:0] b1, b2);
        logic [7:0] e, g;
        model(b1, b2, e);
        i_sbio_host_model.send(b1);
        i_sbio_host_model.send(b2);
        get(g);
        check("reply", 32'(e), 32'(g));
        pins_chk();
    endtask : cmd
    task automatic half(output int k);
        logic s;
        for (int j = 0; j < 2; j++) begin
            s = pin_oe_o[2];
            k = 0;
            while (pin_oe_o[2] === s && k < 400) begin
                @(posedge clk_i);
                k++;
            end
            check("blink_wait", 32'h1, 32'(k < 400));
        end
    endtask : half
    initial begin
        reset_i = 1'b1;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        reg_addr_i = 4'h0;
        reg_wdata_i = 32'h0;
        wr_m = '0;
        val_m = '0;
        void'($urandom(32'hEB33EA2D));
        pin_in_i = 11'($urandom);
        repeat (6) @(posedge clk_i);
        reset_i <= 1'b0;
        rd(4'h0, d);
        check("ctrl", 32'h1, d);
        rd(4'h8, d);
        check("drive", 32'h0, d);
        rd(4'h4, d);
        check("pins", 32'(pin_in_i), d);
        wr(4'h4, 32'h7FF);
        rd(4'hC, d);
        check("unmapped", 32'h0, d);
        half(n);
        check("slow_half", SLOW, n);
        banner();
        for (int p = 1; p <= 11; p++) begin
            cmd({4'hF, 4'(p)}, {7'h00, 1'($urandom)});
            pin_in_i <= 11'($urandom);
            @(posedge clk_i);
            cmd({4'hE, 4'(p)}, 8'h00);
        end
        foreach (bad[i]) cmd(bad[i][15:8], bad[i][7:0]);
        cmd(8'hC1, 8'h01);
        half(n);
        check("fast_half", FAST, n);
        cmd(8'hC1, 8'h00);
        cmd(8'hC0, 8'h00);
        for (int v = 0; v < 2; v++) begin
            cmd(8'hF3, 8'(v));
            check("ind_oe", 32'(1 - v), 32'(pin_oe_o[2]));
        end
        cmd(8'hFA, 8'h01);
        wr(4'h0, 32'h4);
        tw_m = 1;
        rd(4'h0, d);
        check("ctrl", 32'h4, d);
        cmd(8'hFB, 8'h00);
        cmd(8'hFB, 8'h01);
        cmd(8'hFA, 8'h00);
        reset_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        check("oe_reset", 32'h0, 32'(pin_oe_o));
        i_sbio_host_model.rx_q.delete();
        reset_i <= 1'b0;
        wr_m = '0;
        tw_m = 0;
        rd(4'h0, d);
        check("ctrl", 32'h1, d);
        banner();
        cmd(8'hF1, 8'h01);
        results();
    end
endmodule : tb_top
`default_nettype wire
